// File: hw/csit_tx_regs.sv
// Control, status and event-flag register bank of the CSI-2 transmit port, plus link-side sequencing.
// Assumes a byte-wide register port from the serial control target and core-clock receive status.
//
// What this block does
// - With initial calibration on, deskew is sent before any high-speed data.
// - Lane-count code 00/01/10/11 selects four/three/two/one data lanes.
// - Low-power code 00 normal, 01 data lanes LP00, 11 all lanes LP00.
// - Continuous clock mode keeps the clock lane running after the first packet.
// - Output is driven only while the output-enable bit is one.
// - Pass mode 0 needs any enabled port valid, mode 1 needs all.
// - Deskew pattern is 01010101, or 10101010 when inverted.
// - Single-calibration bit sends one deskew at next idle, or at an earlier Frame End with periodic calibration on, then self-clears.
// - Periodic calibration inserts a deskew after each Frame End seen while the link is in CSIT_L_RUN.
// - Synchronized status reads zero whenever synchronized forwarding is off.
// - Non-synchronized pass means actively delivering; an error clears it.
// - Synchronized pass means only that valid data is available.
// - Five interrupt enables at bits 4:0 gate flag-setting events into the port interrupt.
// - Forwarded flag sets on routed port interrupt, clears on port status read.
// - Align-error flag latches on sync error; bits 3:0 clear on read.
// - Aligned flag latches on each rise of synchronized status.
// - Valid-lost flag latches when a forwarded port loses valid.
// - Valid flag latches when the port asserts pass.
// - Sixteen-bit test pattern split into upper and lower byte registers.
// - Speed code 00 1.6G, 10 800M, 11 400M; 01 reserved.
// - Duplication presents port 0 data on the second output too.
// - Summary interrupt clears when the interrupt status register is read.
`include "csit_params.svh"
module csit_tx_regs (
  // Core clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Receive side, core clock
  input wire logic [1:0] i_rx_enabled,
  input wire logic [1:0] i_rx_valid,
  input wire logic [1:0] i_rx_irq,
  input wire logic i_rx_status_read,
  input wire logic i_sync_mode_on,
  input wire logic i_sync_locked,
  input wire logic i_sync_error,
  input wire logic i_tx_fault,
  input wire logic i_duplicate_enable,
  input wire logic [1:0] i_tx_speed,
  output logic o_transmitter_summary_irq,
  // Link side, link clock
  input wire logic i_link_clock,
  input wire logic i_link_first_packet,
  input wire logic i_link_idle,
  input wire logic i_link_frame_end,
  output logic o_tx_enable,
  output logic o_data_lp00,
  output logic o_clock_lp00,
  output logic o_clock_continuous,
  output logic [2:0] o_lane_count,
  output logic o_duplicate,
  output csit_pkg::csit_rate_t o_lane_rate,
  output logic o_hs_allowed,
  output logic o_deskew_active,
  output logic [7:0] o_deskew_byte
);
  import csit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [6:0] output_ctl;
  logic [3:0] cal_ctl;
  logic [4:0] irq_enable;
  logic [4:0] flags;
  logic [7:0] test_ctl;
  logic [7:0] patt_upper;
  logic [7:0] patt_lower;
  logic [7:0] tune_a;
  logic [7:0] tune_b;
  logic pass_level;
  logic sync_level;
  logic [1:0] prev_valid;
  logic summary;
  logic single_req_tgl;
  logic link_done_tgl;
  logic [2:0] done_sync;
  logic single_done;
  logic wr_ctl;
  logic wr_cal;
  logic rd_isr;
  logic next_pass;
  logic [4:0] events;

  assign wr_ctl = i_reg_wr && (i_reg_addr == `CSIT_OFS_OUTPUT_CTL);
  assign wr_cal = i_reg_wr && (i_reg_addr == `CSIT_OFS_CAL_CTL);
  assign rd_isr = i_reg_rd && (i_reg_addr == `CSIT_OFS_IRQ_STS);
  // Done toggle comes back from the link clock
  assign single_done = done_sync[1] ^ done_sync[2];

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      output_ctl <= 7'h00;
      irq_enable <= 5'h00;
      test_ctl <= `CSIT_RST_ZERO;
      patt_upper <= `CSIT_RST_ZERO;
      patt_lower <= `CSIT_RST_ZERO;
      tune_a <= `CSIT_RST_TUNE_A;
      tune_b <= `CSIT_RST_TUNE_B;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `CSIT_OFS_OUTPUT_CTL: output_ctl <= i_reg_wdata[6:0];
        `CSIT_OFS_IRQ_EN: irq_enable <= i_reg_wdata[4:0];
        `CSIT_OFS_TEST_CTL: test_ctl <= i_reg_wdata;
        `CSIT_OFS_PATT_UPPER: patt_upper <= i_reg_wdata;
        `CSIT_OFS_PATT_LOWER: patt_lower <= i_reg_wdata;
        `CSIT_OFS_TUNE_A: tune_a <= i_reg_wdata;
        `CSIT_OFS_TUNE_B: tune_b <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Single bit stays set until the link reports the sequence sent
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_ctl <= 4'h0;
      single_req_tgl <= 1'b0;
    end else begin
      if (wr_cal) begin
        cal_ctl[3] <= i_reg_wdata[3];
        cal_ctl[2] <= i_reg_wdata[2];
        cal_ctl[0] <= i_reg_wdata[0];
      end
      if (wr_cal && i_reg_wdata[`CSIT_BIT_SINGLE] && !cal_ctl[`CSIT_BIT_SINGLE]) begin
        cal_ctl[`CSIT_BIT_SINGLE] <= 1'b1;
        single_req_tgl <= ~single_req_tgl;
      end else if (single_done) begin
        cal_ctl[`CSIT_BIT_SINGLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      done_sync <= 3'h0;
    end else begin
      done_sync <= {done_sync[1:0], link_done_tgl};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pass and synchronized status
  always_comb begin
    if (cal_ctl[3]) begin
      next_pass = (i_rx_enabled != 2'h0) && ((i_rx_valid & i_rx_enabled) == i_rx_enabled);
    end else begin
      next_pass = |(i_rx_valid & i_rx_enabled);
    end
    // Sync mode reports availability only; otherwise a fault stops delivery
    if (!i_sync_mode_on) begin
      next_pass = next_pass && !i_tx_fault && output_ctl[0];
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pass_level <= 1'b0;
      sync_level <= 1'b0;
      prev_valid <= 2'h0;
    end else begin
      pass_level <= next_pass;
      sync_level <= i_sync_mode_on && i_sync_locked;
      prev_valid <= i_rx_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags; set always beats the clearing read
  assign events[4] = |(i_rx_irq & i_rx_enabled);
  assign events[3] = i_sync_error;
  assign events[2] = i_sync_mode_on && i_sync_locked && !sync_level;
  assign events[1] = |(prev_valid & ~i_rx_valid & i_rx_enabled);
  assign events[0] = next_pass && !pass_level;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      flags <= 5'h00;
    end else begin
      flags[4] <= events[4] || (flags[4] && !i_rx_status_read);
      flags[3:0] <= events[3:0] | (flags[3:0] & {4{!rd_isr}});
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      summary <= 1'b0;
    end else begin
      summary <= (|(events & irq_enable)) || (summary && !rd_isr);
    end
  end
  assign o_transmitter_summary_irq = summary;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; flags shown as before the clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= `CSIT_RST_ZERO;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `CSIT_OFS_OUTPUT_CTL: o_reg_rdata <= {1'b0, output_ctl};
        `CSIT_OFS_CAL_CTL: o_reg_rdata <= {`CSIT_CAL_CTL_FIXED, cal_ctl};
        `CSIT_OFS_PORT_STS: o_reg_rdata <= {6'h00, sync_level, pass_level};
        `CSIT_OFS_IRQ_EN: o_reg_rdata <= {3'h0, irq_enable};
        `CSIT_OFS_IRQ_STS: o_reg_rdata <= {3'h0, flags};
        `CSIT_OFS_TEST_CTL: o_reg_rdata <= test_ctl;
        `CSIT_OFS_PATT_UPPER: o_reg_rdata <= patt_upper;
        `CSIT_OFS_PATT_LOWER: o_reg_rdata <= patt_lower;
        `CSIT_OFS_TUNE_A: o_reg_rdata <= tune_a;
        `CSIT_OFS_TUNE_B: o_reg_rdata <= tune_b;
        default: o_reg_rdata <= `CSIT_RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the link clock
  // Fields are synchronised bit by bit; a write may tear for one link cycle, harmless for static setup.
  csit_link_ctrl_t ctrl_core;
  csit_link_ctrl_t ctrl_s1;
  csit_link_ctrl_t ctrl_s2;
  logic [2:0] req_sync;
  logic single_pending;
  logic cal_is_single;
  logic first_seen;
  logic [7:0] cal_count;
  csit_link_state_t link_state;

  assign ctrl_core = '{enable: output_ctl[0], init_cal: output_ctl[6], lanes: output_ctl[5:4],
                       low_power: output_ctl[3:2], cont_clock: output_ctl[1], periodic: cal_ctl[0],
                       invert: cal_ctl[2], duplicate: i_duplicate_enable, speed: i_tx_speed};

  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_s1 <= '0;
      ctrl_s2 <= '0;
      req_sync <= 3'h0;
    end else begin
      ctrl_s1 <= ctrl_core;
      ctrl_s2 <= ctrl_s1;
      req_sync <= {req_sync[1:0], single_req_tgl};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      single_pending <= 1'b0;
    end else if (req_sync[1] ^ req_sync[2]) begin
      single_pending <= 1'b1;
    end else if (link_state == CSIT_L_CAL && cal_is_single) begin
      single_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link_state <= CSIT_L_INIT;
      cal_count <= 8'h00;
      cal_is_single <= 1'b0;
      link_done_tgl <= 1'b0;
    end else if (!ctrl_s2.enable) begin
      link_state <= CSIT_L_INIT;
      cal_count <= 8'h00;
      cal_is_single <= 1'b0;
    end else begin
      unique case (link_state)
        CSIT_L_INIT: begin
          cal_count <= `CSIT_DESKEW_CYCLES;
          cal_is_single <= 1'b0;
          link_state <= ctrl_s2.init_cal ? CSIT_L_CAL : CSIT_L_RUN;
        end
        CSIT_L_CAL: begin
          cal_count <= cal_count - 8'h01;
          if (cal_count == 8'h01) begin
            link_state <= CSIT_L_RUN;
            if (cal_is_single) begin
              link_done_tgl <= ~link_done_tgl;
            end
          end
        end
        CSIT_L_RUN: begin
          cal_count <= `CSIT_DESKEW_CYCLES;
          if (i_link_frame_end && ctrl_s2.periodic) begin
            link_state <= CSIT_L_CAL;
            cal_is_single <= single_pending;
          end else if (i_link_idle && single_pending) begin
            link_state <= CSIT_L_CAL;
            cal_is_single <= 1'b1;
          end
        end
        default: link_state <= CSIT_L_INIT;
      endcase
    end
  end

  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      first_seen <= 1'b0;
    end else if (!ctrl_s2.enable) begin
      first_seen <= 1'b0;
    end else if (i_link_first_packet) begin
      first_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link outputs, registered
  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_enable <= 1'b0;
      o_data_lp00 <= 1'b0;
      o_clock_lp00 <= 1'b0;
      o_clock_continuous <= 1'b0;
      o_lane_count <= `CSIT_MAX_LANES;
      o_duplicate <= 1'b0;
      o_lane_rate <= CSIT_RATE_1G6;
      o_hs_allowed <= 1'b0;
      o_deskew_active <= 1'b0;
      o_deskew_byte <= `CSIT_DESKEW_PATTERN;
    end else begin
      o_tx_enable <= ctrl_s2.enable;
      o_data_lp00 <= (ctrl_s2.low_power == `CSIT_LP_DATA) || (ctrl_s2.low_power == `CSIT_LP_ALL);
      o_clock_lp00 <= ctrl_s2.low_power == `CSIT_LP_ALL;
      o_clock_continuous <= ctrl_s2.enable && ctrl_s2.cont_clock && (first_seen || i_link_first_packet);
      o_lane_count <= `CSIT_MAX_LANES - {1'b0, ctrl_s2.lanes};
      o_duplicate <= ctrl_s2.enable && ctrl_s2.duplicate;
      o_lane_rate <= csit_rate_t'(ctrl_s2.speed);
      // Reserved low-power code 10 behaves as normal operation
      o_hs_allowed <= ctrl_s2.enable && link_state == CSIT_L_RUN && !o_data_lp00;
      o_deskew_active <= ctrl_s2.enable && link_state == CSIT_L_CAL;
      // Leftmost bit goes out first
      o_deskew_byte <= ctrl_s2.invert ? ~`CSIT_DESKEW_PATTERN : `CSIT_DESKEW_PATTERN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  clear_keeps_event_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    rd_isr && events[3] |=> flags[3]) else $error("Event lost on clearing read");
  flag_cleared_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    rd_isr && events[3:0] == 4'h0 |=> flags[3:0] == 4'h0) else $error("Flags not cleared by read");
  sync_off_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !i_sync_mode_on |=> !sync_level) else $error("Sync status set while sync forwarding off");
  pass_event_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(pass_level) |-> flags[0]) else $error("Pass rise did not set flag");
  summary_gate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(summary) |-> |($past(events) & $past(irq_enable))) else $error("Summary raised without enabled event");
  lane_decode_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
    ctrl_s2.lanes == 2'h3 |=> o_lane_count == 3'h1) else $error("Lane code 11 not one lane");
  no_hs_before_cal_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
    link_state == CSIT_L_INIT && ctrl_s2.enable && ctrl_s2.init_cal |=> ##1 !o_hs_allowed [*8])
    else $error("High-speed data before initial deskew");
  periodic_after_fe_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
    link_state == CSIT_L_RUN && ctrl_s2.enable && i_link_frame_end && ctrl_s2.periodic |=> link_state == CSIT_L_CAL)
    else $error("No deskew after Frame End");
  output_off_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
    !ctrl_s2.enable |=> !o_tx_enable && !o_hs_allowed) else $error("Output driven while disabled");
  single_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    single_done |=> !cal_ctl[`CSIT_BIT_SINGLE]) else $error("Single bit not self-cleared");
endmodule

// File: hw/csit_params.svh
// Offsets, field positions, reset values and timing for the CSI-2 transmit register bank.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CSIT_PARAMS_SVH
`define CSIT_PARAMS_SVH
`define CSIT_OFS_OUTPUT_CTL 8'h33
`define CSIT_OFS_CAL_CTL 8'h34
`define CSIT_OFS_PORT_STS 8'h35
`define CSIT_OFS_IRQ_EN 8'h36
`define CSIT_OFS_IRQ_STS 8'h37
`define CSIT_OFS_TEST_CTL 8'h38
`define CSIT_OFS_PATT_UPPER 8'h39
`define CSIT_OFS_PATT_LOWER 8'h3a
`define CSIT_OFS_TUNE_A 8'h3b
`define CSIT_OFS_TUNE_B 8'h3c
`define CSIT_RST_ZERO 8'h00
`define CSIT_RST_TUNE_A 8'h01
`define CSIT_RST_TUNE_B 8'h14
`define CSIT_CAL_CTL_FIXED 4'h4
`define CSIT_BIT_SINGLE 1
`define CSIT_LP_NORMAL 2'h0
`define CSIT_LP_DATA 2'h1
`define CSIT_LP_ALL 2'h3
`define CSIT_MAX_LANES 3'h4
`define CSIT_DESKEW_PATTERN 8'h55
`define CSIT_DESKEW_CYCLES 8'h20
`endif

// File: hw/csit_pkg.sv
// Types shared by the CSI-2 transmit register bank.
// Assumes csit_params.svh is on the include path.
package csit_pkg;
  typedef enum logic [1:0] {
    CSIT_RATE_1G6 = 2'b00,
    CSIT_RATE_RSVD = 2'b01,
    CSIT_RATE_800M = 2'b10,
    CSIT_RATE_400M = 2'b11
  } csit_rate_t;
  typedef enum logic [1:0] {
    CSIT_L_INIT = 2'b00,
    CSIT_L_CAL = 2'b01,
    CSIT_L_RUN = 2'b10
  } csit_link_state_t;
  typedef struct packed {
    logic enable;
    logic init_cal;
    logic [1:0] lanes;
    logic [1:0] low_power;
    logic cont_clock;
    logic periodic;
    logic invert;
    logic duplicate;
    logic [1:0] speed;
  } csit_link_ctrl_t;
endpackage

// File: verif/csit_rx_partner.sv
// Far-side receiver model: idle and frame-end events, deskew burst capture.
// Assumes the transmit bank's link outputs, all on the link clock.
module csit_rx_partner (
  // Link clock and reset
  input wire logic i_link_clock,
  input wire logic i_resetn,
  // Bench request and transmitter view
  input wire logic i_frame_req,
  input wire logic i_deskew_active,
  input wire logic [7:0] i_deskew_byte,
  // Events and burst capture
  output logic o_first_packet,
  output logic o_idle,
  output logic o_frame_end,
  output logic [7:0] o_bursts,
  output logic [7:0] o_burst_len,
  output logic [7:0] o_burst_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] tick;
  logic req_seen;
  logic act_q;
  logic [7:0] len;
  ////////////////////////////////////////////////////////////
  // Idle gaps recur every 64 cycles, like a line blanking period
  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tick <= 6'h00;
      req_seen <= 1'b0;
      o_first_packet <= 1'b0;
      o_idle <= 1'b0;
      o_frame_end <= 1'b0;
    end else begin
      tick <= tick + 6'h01;
      req_seen <= i_frame_req;
      o_first_packet <= (tick == 6'h08);
      o_idle <= (tick == 6'h3f);
      o_frame_end <= (i_frame_req != req_seen);
    end
  end
  // Burst length counts link cycles with deskew showing
  always_ff @(posedge i_link_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      act_q <= 1'b0;
      len <= 8'h00;
      o_bursts <= 8'h00;
      o_burst_len <= 8'h00;
      o_burst_byte <= 8'h00;
    end else begin
      act_q <= i_deskew_active;
      if (i_deskew_active) len <= act_q ? len + 8'h01 : 8'h01;
      if (i_deskew_active && !act_q) o_burst_byte <= i_deskew_byte;
      if (!i_deskew_active && act_q) begin
        o_bursts <= o_bursts + 8'h01;
        o_burst_len <= len;
      end
    end
  end
endmodule

// File: verif/csit_tx_regs_tb_top.sv
// Self-checking bench for the CSI-2 transmit register bank.
// Assumes csit_rx_partner stands at the link side.
`include "csit_params.svh"
module csit_tx_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import csit_pkg::*;
  logic i_clock = 1'b0, i_resetn = 1'b0, link_clk = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, bursts, blen, bbyte, dbyte;
  logic wr = 1'b0, rd = 1'b0, rx_read = 1'b0, sync_on = 1'b0, locked = 1'b0, sync_err = 1'b0;
  logic fault = 1'b0, dup = 1'b0, frame_req = 1'b0;
  logic [1:0] rx_en = 2'h3, rx_valid = 2'h0, rx_irq = 2'h0, speed = 2'h0;
  logic irq, first_pkt, idle, fend, tx_en, d_lp, c_lp, c_cont, dup_o, hs, dsk;
  logic [2:0] lanes;
  csit_rate_t rate;
  int n_mismatch = 0, compares = 0;
  always #25 i_clock = ~i_clock;
  always #24 link_clk = ~link_clk;
  ////////////////////////////////////////////////////////////
  csit_tx_regs uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_enabled(rx_en),
    .i_rx_valid(rx_valid), .i_rx_irq(rx_irq), .i_rx_status_read(rx_read), .i_sync_mode_on(sync_on),
    .i_sync_locked(locked), .i_sync_error(sync_err), .i_tx_fault(fault), .i_duplicate_enable(dup),
    .i_tx_speed(speed), .o_transmitter_summary_irq(irq), .i_link_clock(link_clk),
    .i_link_first_packet(first_pkt), .i_link_idle(idle), .i_link_frame_end(fend),
    .o_tx_enable(tx_en), .o_data_lp00(d_lp), .o_clock_lp00(c_lp), .o_clock_continuous(c_cont),
    .o_lane_count(lanes), .o_duplicate(dup_o), .o_lane_rate(rate), .o_hs_allowed(hs),
    .o_deskew_active(dsk), .o_deskew_byte(dbyte));
  csit_rx_partner far_end (.i_link_clock(link_clk), .i_resetn(i_resetn), .i_frame_req(frame_req),
    .i_deskew_active(dsk), .i_deskew_byte(dbyte), .o_first_packet(first_pkt), .o_idle(idle),
    .o_frame_end(fend), .o_bursts(bursts), .o_burst_len(blen), .o_burst_byte(bbyte));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wait_link(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a);
    check(rdata, exp);
  endtask
  // Optional frame end, then one whole deskew burst seen by the far end
  task automatic wait_burst(input logic fe);
    logic [7:0] b0;
    b0 = bursts;
    if (fe) frame_req <= ~frame_req;
    for (int k = 0; k < 300 && bursts === b0; k++) @(posedge link_clk);
    #1 check(bursts, b0 + 8'h01);
  endtask
  task automatic drive(input logic [1:0] v, input logic f, input logic s, input logic lk);
    @(posedge i_clock);
    rx_valid <= v;
    fault <= f;
    sync_on <= s;
    locked <= lk;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_check(`CSIT_OFS_TUNE_A, `CSIT_RST_TUNE_A);
    rd_check(`CSIT_OFS_TUNE_B, `CSIT_RST_TUNE_B);
    rd_check(`CSIT_OFS_TEST_CTL, `CSIT_RST_ZERO);
    rd_check(`CSIT_OFS_CAL_CTL, {`CSIT_CAL_CTL_FIXED, 4'h0});
    rd_check(8'h50, 8'h00);
    check({5'h00, lanes}, 8'h04);
    wr_reg(`CSIT_OFS_PORT_STS, 8'hff);
    rd_check(`CSIT_OFS_PORT_STS, 8'h00);
  endtask
  task automatic t_pattern();
    wr_reg(`CSIT_OFS_PATT_UPPER, 8'ha5);
    wr_reg(`CSIT_OFS_PATT_LOWER, 8'h3c);
    rd_check(`CSIT_OFS_PATT_UPPER, 8'ha5);
    rd_check(`CSIT_OFS_PATT_LOWER, 8'h3c);
  endtask
  task automatic t_link();
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      speed <= i[1:0];
      dup <= i[1];
      wr_reg(`CSIT_OFS_OUTPUT_CTL, {2'b00, i[1:0], i[1:0], i[0], 1'b1});
      wait_link(70);
      check({5'h00, lanes}, 8'h04 - i[7:0]);
      check({6'h00, rate}, {6'h00, i[1:0]});
      check({5'h00, tx_en, d_lp, c_lp}, {5'h00, 1'b1, i[0], i == 3});
      check({6'h00, c_cont, dup_o}, {6'h00, i[0], i[1]});
    end
  endtask
  task automatic t_init_cal();
    wr_reg(`CSIT_OFS_OUTPUT_CTL, 8'h00);
    wait_link(8);
    check({7'h00, tx_en}, 8'h00);
    wr_reg(`CSIT_OFS_OUTPUT_CTL, 8'h41);
    for (int k = 0; k < 50 && dsk !== 1'b1; k++) @(posedge link_clk);
    #1 check({6'h00, dsk, hs}, 8'h02);
    check(dbyte, `CSIT_DESKEW_PATTERN);
    wait_burst(1'b0);
    check(blen, `CSIT_DESKEW_CYCLES);
    wait_link(4);
    check({7'h00, hs}, 8'h01);
  endtask
  task automatic t_periodic();
    for (int j = 0; j < 2; j++) begin
      wr_reg(`CSIT_OFS_CAL_CTL, {5'h00, j[0], 2'b01});
      wait_link(8);
      wait_burst(1'b1);
      check(bbyte, j[0] ? 8'haa : `CSIT_DESKEW_PATTERN);
      check(blen, `CSIT_DESKEW_CYCLES);
    end
  endtask
  task automatic t_single();
    wr_reg(`CSIT_OFS_CAL_CTL, 8'h02);
    wait_burst(1'b0);
    check(bbyte, `CSIT_DESKEW_PATTERN);
    cyc(12);
    rd_check(`CSIT_OFS_CAL_CTL, {`CSIT_CAL_CTL_FIXED, 4'h0});
  endtask
  task automatic t_status();
    drive(2'h1, 1'b0, 1'b0, 1'b1);
    rd_check(`CSIT_OFS_PORT_STS, 8'h01);
    wr_reg(`CSIT_OFS_CAL_CTL, 8'h08);
    cyc(4);
    rd_check(`CSIT_OFS_PORT_STS, 8'h00);
    // Only port 0 forwarded: all-mode pass needs just that port
    @(posedge i_clock);
    rx_en <= 2'h1;
    cyc(4);
    rd_check(`CSIT_OFS_PORT_STS, 8'h01);
    @(posedge i_clock);
    rx_en <= 2'h3;
    drive(2'h3, 1'b0, 1'b0, 1'b1);
    rd_check(`CSIT_OFS_PORT_STS, 8'h01);
    drive(2'h3, 1'b1, 1'b0, 1'b1);
    rd_check(`CSIT_OFS_PORT_STS, 8'h00);
    drive(2'h3, 1'b1, 1'b1, 1'b1);
    rd_check(`CSIT_OFS_PORT_STS, 8'h03);
  endtask
  task automatic t_irq();
    wr_reg(`CSIT_OFS_CAL_CTL, 8'h00);
    drive(2'h0, 1'b0, 1'b0, 1'b0);
    rd_reg(`CSIT_OFS_IRQ_STS);
    @(posedge i_clock);
    sync_err <= 1'b1;
    @(posedge i_clock);
    sync_err <= 1'b0;
    cyc(3);
    check({7'h00, irq}, 8'h00);
    rd_check(`CSIT_OFS_IRQ_STS, 8'h08);
    rd_check(`CSIT_OFS_IRQ_STS, 8'h00);
    wr_reg(`CSIT_OFS_IRQ_EN, 8'h1f);
    rd_check(`CSIT_OFS_IRQ_EN, 8'h1f);
    drive(2'h1, 1'b0, 1'b1, 1'b1);
    drive(2'h0, 1'b0, 1'b1, 1'b1);
    @(posedge i_clock);
    rx_irq <= 2'h2;
    cyc(4);
    check({7'h00, irq}, 8'h01);
    rd_check(`CSIT_OFS_IRQ_STS, 8'h17);
    @(posedge i_clock);
    rx_irq <= 2'h0;
    rx_read <= 1'b1;
    @(posedge i_clock);
    rx_read <= 1'b0;
    cyc(3);
    rd_check(`CSIT_OFS_IRQ_STS, 8'h00);
    cyc(2);
    check({7'h00, irq}, 8'h00);
    // Event lands in the very cycle of the clearing read
    @(posedge i_clock);
    addr <= `CSIT_OFS_IRQ_STS;
    rd <= 1'b1;
    sync_err <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    sync_err <= 1'b0;
    #1 check(rdata, 8'h00);
    rd_check(`CSIT_OFS_IRQ_STS, 8'h08);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    t_reset();
    t_pattern();
    t_link();
    t_init_cal();
    t_periodic();
    t_single();
    t_status();
    t_irq();
    final_report();
  end
  // Whole run needs well under a tenth of this span
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
endmodule
